// *** rsttrk_top.sv ***
// The Wishbone interface to the registers was chosen for this implementation.
`default_nettype none
module rsttrk_top
    import rsttrk_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic watchdog_reset_request,
    input wire logic low_voltage_detector,
    input wire logic clock_monitor,
    output logic sys_reset,
    output logic cpu_hold,
    output logic cpu_start,
    output logic [31:0] fetch_address,
    output logic emergency_mode,
    output logic clk_sel_internal,
    output logic irq
);
    localparam int CNT_MAX = (STAB_CYCLES > RST_HOLD_CYCLES) ? STAB_CYCLES : RST_HOLD_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RST_HOLD_CYCLES);
    localparam logic [CNT_W-1:0] STAB_LOAD = CNT_W'(STAB_CYCLES);

    function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] target);
        hit = (adr[ADDR_W-1:2] == target[ADDR_W-1:2]);
    endfunction

    // ==========================================================
    // reset release synchroniser; the pin reset is the power-on reset too
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // wishbone slave: ack one cycle after the request, dropped the next
    logic req;
    logic wr;
    logic next_ack;
    logic [DATA_W-1:0] next_dat;
    logic hit_flags;
    logic hit_cmd;
    logic hit_status;
    logic hit_mask;
    logic hit_state;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign hit_flags = hit(wb_adr_i, ADDR_FLAGS);
    assign hit_cmd = hit(wb_adr_i, ADDR_PROT_CMD);
    assign hit_status = hit(wb_adr_i, ADDR_IRQ_STATUS);
    assign hit_mask = hit(wb_adr_i, ADDR_IRQ_MASK);
    assign hit_state = hit(wb_adr_i, ADDR_STATE);

    // ==========================================================
    // protected write sequence
    logic prot_allow;
    logic prot_error;

    rsttrk_protect u_protect (
        .clk(clk_sys),
        .rst_n(rst_n),
        .wr(wr),
        .hit_cmd(hit_cmd),
        .hit_special(hit_flags),
        .allow(prot_allow),
        .error(prot_error)
    );

    // ==========================================================
    // timers for reset hold and oscillator stabilisation
    logic hold_load;
    logic stab_load;
    logic hold_done;
    logic stab_done;

    rsttrk_timer #(
        .CNT_W(CNT_W)
    ) u_hold (
        .clk(clk_sys),
        .rst_n(rst_n),
        .load(hold_load),
        .load_val(HOLD_LOAD),
        .busy(),
        .done(hold_done)
    );

    rsttrk_timer #(
        .CNT_W(CNT_W)
    ) u_stab (
        .clk(clk_sys),
        .rst_n(rst_n),
        .load(stab_load),
        .load_val(STAB_LOAD),
        .busy(),
        .done(stab_done)
    );

    // ==========================================================
    // reset sequencer
    rsttrk_state_t state;
    rsttrk_state_t next_state;
    logic boot;
    logic next_boot;
    logic next_emergency;
    logic evt_wdt_rst;
    logic evt_emerg;
    logic evt_int;

    // a watchdog overflow while the oscillator settles is no reset cause
    assign evt_wdt_rst = watchdog_reset_request & (state != ST_STAB);
    assign evt_emerg = watchdog_reset_request & (state == ST_STAB) & ~boot;
    assign evt_int = evt_wdt_rst | low_voltage_detector | clock_monitor;

    always_comb begin
        next_state = state;
        next_boot = 1'b0;
        next_emergency = emergency_mode;
        hold_load = 1'b0;
        stab_load = 1'b0;
        case (state)
            ST_HOLD: begin
                if (boot || evt_int) begin
                    hold_load = 1'b1;
                end else if (hold_done) begin
                    next_state = ST_STAB;
                    stab_load = 1'b1;
                end
            end
            ST_STAB: begin
                if (evt_emerg) begin
                    next_state = ST_RUN;
                    next_emergency = 1'b1;
                end else if (low_voltage_detector || clock_monitor) begin
                    next_state = ST_HOLD;
                    hold_load = 1'b1;
                end else if (stab_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (evt_int) begin
                    next_state = ST_HOLD;
                    hold_load = 1'b1;
                    next_emergency = 1'b0;
                end
            end
            default: begin
                next_state = ST_HOLD;
                hold_load = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_HOLD;
            boot <= 1'b1;
            emergency_mode <= 1'b0;
            clk_sel_internal <= 1'b0;
            sys_reset <= 1'b1;
            cpu_hold <= 1'b1;
            cpu_start <= 1'b0;
            fetch_address <= RESET_VECTOR;
        end else begin
            state <= next_state;
            boot <= next_boot;
            emergency_mode <= next_emergency;
            clk_sel_internal <= next_emergency;
            sys_reset <= (next_state == ST_HOLD);
            cpu_hold <= (next_state != ST_RUN);
            cpu_start <= (next_state == ST_RUN) && (state != ST_RUN);
            if ((next_state == ST_RUN) && (state != ST_RUN)) begin
                fetch_address <= RESET_VECTOR;
            end
        end
    end

    // ==========================================================
    // reset cause flags; kept across internal resets, cleared by the pin
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] set_flags;

    always_comb begin
        set_flags = 8'h00;
        set_flags[FLAG_WDT_BIT] = evt_wdt_rst;
        set_flags[FLAG_CLK_BIT] = clock_monitor;
        set_flags[FLAG_LVD_BIT] = low_voltage_detector;
        next_flags = flags;
        // a byte write with ones everywhere but one bit is the single bit clear
        if (prot_allow && wb_sel_i[0]) begin
            next_flags = flags & wb_dat_i[7:0];
        end
        next_flags = (next_flags | set_flags) & FLAGS_USED;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // ==========================================================
    // interrupt status, write one to clear, set wins
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_status;
    logic [IRQ_W-1:0] next_mask;
    logic [IRQ_W-1:0] irq_set;

    always_comb begin
        irq_set = IRQ_RESET;
        irq_set[IRQ_LVD_BIT] = low_voltage_detector;
        irq_set[IRQ_CLK_BIT] = clock_monitor;
        irq_set[IRQ_EMERG_BIT] = evt_emerg;
        irq_set[IRQ_WDT_BIT] = evt_wdt_rst;
        // only a refused flag write counts, or the error bit could never be cleared
        irq_set[IRQ_PROT_BIT] = prot_error & hit_flags & wb_sel_i[0];
        next_status = irq_status;
        next_mask = irq_mask;
        if (wr && wb_sel_i[0] && hit_status) begin
            next_status = irq_status & ~wb_dat_i[IRQ_W-1:0];
        end
        if (wr && wb_sel_i[0] && hit_mask) begin
            next_mask = wb_dat_i[IRQ_W-1:0];
        end
        next_status = next_status | irq_set;
    end

    // ==========================================================
    // read path; unmapped addresses answer with zero
    always_comb begin
        next_ack = req;
        next_dat = '0;
        if (req && !wb_we_i) begin
            if (hit_flags) begin
                next_dat[7:0] = flags;
            end else if (hit_status) begin
                next_dat[IRQ_W-1:0] = irq_status;
            end else if (hit_mask) begin
                next_dat[IRQ_W-1:0] = irq_mask;
            end else if (hit_state) begin
                next_dat[2:0] = state;
                next_dat[STATE_EMERG_BIT] = emergency_mode;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            irq <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            irq_status <= next_status;
            irq_mask <= next_mask;
            irq <= |(next_status & next_mask);
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end
endmodule
`default_nettype wire

// *** rsttrk_pkg.sv ***
`default_nettype none
package rsttrk_pkg;
    // ==========================================================
    // bus and register map (byte addresses)
    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 28'hFFFF888;
    localparam logic [ADDR_W-1:0] ADDR_PROT_CMD = 28'hFFFF880;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 28'hFFFF88C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 28'hFFFF890;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 28'hFFFF894;

    // ==========================================================
    // reset cause flag layout
    localparam int FLAG_LVD_BIT = 0;
    localparam int FLAG_CLK_BIT = 1;
    localparam int FLAG_WDT_BIT = 4;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAGS_USED = 8'h13;

    // ==========================================================
    // interrupt status layout
    localparam int IRQ_W = 5;
    localparam int IRQ_LVD_BIT = 0;
    localparam int IRQ_CLK_BIT = 1;
    localparam int IRQ_EMERG_BIT = 2;
    localparam int IRQ_WDT_BIT = 3;
    localparam int IRQ_PROT_BIT = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

    // ==========================================================
    // state register layout
    localparam int STATE_EMERG_BIT = 3;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 25;
    localparam int RST_HOLD_NS = 1000;
    localparam int RST_HOLD_CYCLES = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int STAB_CYCLES_DEF = 16384;
    localparam logic [31:0] RESET_VECTOR = 32'h00000000;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_STAB = 3'b100
    } rsttrk_state_t;
endpackage
`default_nettype wire

// *** rsttrk_timer.sv ***
`default_nettype none
module rsttrk_timer #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_busy;
    logic next_done;

    // ==========================================================
    // down counter, done pulses once as it reaches zero
    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (load) begin
            next_cnt = load_val;
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_cnt = '0;
            end else begin
                next_cnt = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// *** rsttrk_protect.sv ***
`default_nettype none
module rsttrk_protect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic hit_cmd,
    input wire logic hit_special,
    output logic allow,
    output logic error
);
    logic armed;
    logic next_armed;

    // ==========================================================
    // key write arms; only the very next write may touch the special register
    always_comb begin
        next_armed = armed;
        allow = 1'b0;
        error = 1'b0;
        if (wr) begin
            if (hit_cmd) begin
                next_armed = 1'b1;
            end else begin
                next_armed = 1'b0;
                allow = armed & hit_special;
                error = ~(armed & hit_special);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else begin
            armed <= next_armed;
        end
    end
endmodule
`default_nettype wire

// *** rsttrk_top_monitor.sv ***
`default_nettype none
module rsttrk_top_monitor
    import rsttrk_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic watchdog_reset_request,
    input wire logic low_voltage_detector,
    input wire logic clock_monitor,
    input wire logic sys_reset,
    input wire logic cpu_hold,
    input wire logic cpu_start,
    input wire logic [31:0] fetch_address,
    input wire logic emergency_mode,
    input wire logic clk_sel_internal
);
    // ========
    // bus and sequencing checks
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // only events seen in run count; during hold the count restarts instead
    sequence s_src;
        !cpu_hold && (watchdog_reset_request || low_voltage_detector || clock_monitor);
    endsequence
    a_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    a_flag_unused: assert property (s_req ##0 (!wb_we_i && wb_adr_i == ADDR_FLAGS) |=>
        (wb_dat_o & ~{24'h0, FLAGS_USED}) == 32'h0) else $error("unused flag bits not zero");
    a_src_reset: assert property (s_src |-> ##[1:2] sys_reset)
        else $error("reset source ignored");
    a_hold_len: assert property ($rose(sys_reset) |-> sys_reset [*8])
        else $error("internal reset too short");
    a_hold_cpu: assert property (sys_reset |-> cpu_hold)
        else $error("cpu released during reset");
    a_start_vec: assert property (cpu_start |-> fetch_address == RESET_VECTOR)
        else $error("start address not zero");
    a_start_pulse: assert property (cpu_start |=> !cpu_start)
        else $error("start not a single pulse");
    a_emerg_clk: assert property (clk_sel_internal == emergency_mode)
        else $error("clock select differs from emergency");
    a_emerg_cause: assert property ($rose(emergency_mode) |-> $past(cpu_hold) && !sys_reset)
        else $error("emergency outside stabilisation");
endmodule
bind rsttrk_top rsttrk_top_monitor #(.STAB_CYCLES(STAB_CYCLES)) i_rsttrk_top_monitor (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .watchdog_reset_request(watchdog_reset_request), .low_voltage_detector(low_voltage_detector),
    .clock_monitor(clock_monitor), .sys_reset(sys_reset), .cpu_hold(cpu_hold), .cpu_start(cpu_start),
    .fetch_address(fetch_address), .emergency_mode(emergency_mode), .clk_sel_internal(clk_sel_internal)
);
`default_nettype wire

// *** rsttrk_sources.sv ***
`default_nettype none
module rsttrk_sources (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] fire,
    input wire logic [3:0] delay,
    output logic watchdog_reset_request,
    output logic low_voltage_detector,
    output logic clock_monitor
);
    // ========
    // event sources: one high cycle after a chosen delay
    logic [2:0] pend, next_pend;
    logic [3:0] cnt, next_cnt;
    always_comb begin
        next_pend = (cnt == 4'h0) ? 3'h0 : pend;
        next_cnt = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
        if (fire != 3'h0) begin
            next_pend = fire;
            next_cnt = delay;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 3'h0;
            cnt <= 4'h0;
        end else begin
            pend <= next_pend;
            cnt <= next_cnt;
        end
    end
    // pulses, not levels, so a missed sample shows up as a lost event
    assign low_voltage_detector = pend[0] && cnt == 4'h0;
    assign clock_monitor = pend[1] && cnt == 4'h0;
    assign watchdog_reset_request = pend[2] && cnt == 4'h0;
endmodule
`default_nettype wire

// *** tb_rsttrk_top.sv ***
`default_nettype none
module tb_rsttrk_top
    import rsttrk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [ADDR_W-1:0] wb_adr_i = '0;
    logic [DATA_W-1:0] wb_dat_i = '0, wb_dat_o, q;
    logic wb_ack_o, watchdog_reset_request, low_voltage_detector, clock_monitor, sys_reset, cpu_hold;
    logic cpu_start, emergency_mode, clk_sel_internal, irq;
    logic [31:0] fetch_address, rng = 32'h8B4C;
    logic [2:0] fire = 3'h0;
    logic [3:0] dly = 4'h0;
    logic [7:0] flags;
    int n_fail = 0, n_tests = 0, cyc = 0;
    rsttrk_top #(.STAB_CYCLES(20)) i_rsttrk_top (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .watchdog_reset_request(watchdog_reset_request),
        .low_voltage_detector(low_voltage_detector), .clock_monitor(clock_monitor), .sys_reset(sys_reset),
        .cpu_hold(cpu_hold), .cpu_start(cpu_start), .fetch_address(fetch_address),
        .emergency_mode(emergency_mode), .clk_sel_internal(clk_sel_internal), .irq(irq));
    rsttrk_sources i_rsttrk_sources (.clk_sys(clk_sys), .rst_n(nrst), .fire(fire), .delay(dly),
        .watchdog_reset_request(watchdog_reset_request), .low_voltage_detector(low_voltage_detector),
        .clock_monitor(clock_monitor));
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    // ========
    // expectations and bus tasks
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [7:0] f_ev(logic [7:0] o, int b);
        return o | ((b == 2) ? 8'h10 : 8'(1 << b));
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // no local limit: only the bench timeout ends a hung request
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // key write first, and no other write in between, or the flag write is dropped
    task automatic fw(input logic [7:0] d);
        wb(1'b1, ADDR_PROT_CMD, xs());
        wb(1'b1, ADDR_FLAGS, {24'hFFFFFF, d});
        flags = flags & d & FLAGS_USED;
    endtask
    task automatic ev(input int b);
        fire <= 3'(1 << b);
        dly <= 4'(xs() & 32'h7);
        @(posedge clk_sys);
        fire <= 3'h0;
    endtask
    task automatic run_wait();
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (cpu_start !== 1'b1 && k < 200);
        chk({31'h0, cpu_start}, 32'h1);
        chk(fetch_address, RESET_VECTOR);
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ========
    // scenarios
    initial begin
        flags = FLAGS_RESET;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        run_wait();
        rd(ADDR_FLAGS, 32'h0);
        for (int i = 0; i < 7; i++) begin
            ev(i % 3);
            run_wait();
            flags = f_ev(flags, i % 3);
            rd(ADDR_FLAGS, {24'h0, flags});
            chk({31'h0, emergency_mode}, 32'h0);
            if (i > 3) fw(8'(xs()));
            if (i > 3) rd(ADDR_FLAGS, {24'h0, flags});
        end
        rd(ADDR_IRQ_STATUS, 32'h0B);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h1F);
        wb(1'b1, ADDR_IRQ_MASK, 32'h0);
        wb(1'b1, ADDR_FLAGS, 32'h0);
        rd(ADDR_FLAGS, {24'h0, flags});
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, ADDR_IRQ_MASK, 32'h10);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h10);
        chk({31'h0, irq}, 32'h0);
        ev(2);
        run_wait();
        flags = f_ev(flags, 2);
        fw(8'hFF);
        rd(ADDR_FLAGS, {24'h0, flags});
        fw(8'hEF);
        rd(ADDR_FLAGS, {24'h0, flags});
        fork
            begin
                fire <= 3'h1;
                dly <= 4'h2;
                @(posedge clk_sys);
                fire <= 3'h0;
            end
            fw(8'h00);
        join
        run_wait();
        flags = 8'h01;
        rd(ADDR_FLAGS, 32'h01);
        ev(0);
        repeat (33) @(posedge clk_sys);
        ev(2);
        run_wait();
        // no register traffic while running on the internal oscillator
        chk({30'h0, emergency_mode, clk_sel_internal}, 32'h3);
        ev(1);
        run_wait();
        chk({31'h0, emergency_mode}, 32'h0);
        rd(ADDR_FLAGS, 32'h03);
        rd(ADDR_IRQ_STATUS, 32'h0F);
        rd(28'hFFFF8A0, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        run_wait();
        rd(ADDR_FLAGS, 32'h0);
        rd(ADDR_STATE, 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
